// ==== hdl/lmr_pkg.sv ====
// Behaviour
// - Feature bit 0 reports refresh-mode support
// - Self-test field encodes four impedance pin results
// - Self-test valid after start, latch, wait
// - Assembly fault forces factory trim, ignores calibration
// - Read-only bit reports single-ended support
// - Termination bit zero means bus unterminated
// - Burst field selects 16, 32 or per-command
// - Per-command mode uses command burst bit
// - Write preamble bit must be one
// - Read preamble bit selects static or toggling
// - Write recovery code maps to clock count
// - Controller rounds write recovery time up
// - Postamble bit selects half or one-and-half clock
// - Register-1 access reaches write-selected set point
// - Device operates from operate-selected set point
// - Controller writes same burst code both set points; code here follows i_burst_mode at each write
// - Read latency follows read inversion enable
// - Write latency follows set selector bit
// - Controller keeps clock inside chosen band
// - Read-to-precharge count follows band table
// - Burst 32 adds eight precharge clocks; device adds them on reads only, not on writes
package lmr_pkg;

	localparam int MA_W  = 6;
	localparam int OP_W  = 8;
	localparam int LAT_W = 6;

	// ----------------------------------------------------------------
	// Mode register indices
	// ----------------------------------------------------------------
	localparam logic [MA_W-1:0] MA_FEATURE  = 6'h00;
	localparam logic [MA_W-1:0] MA_BURST    = 6'h01;
	localparam logic [MA_W-1:0] MA_LATENCY  = 6'h02;
	localparam logic [MA_W-1:0] MA_INVERT   = 6'h03;
	localparam logic [MA_W-1:0] MA_SETPOINT = 6'h0D;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int FEAT_REFRESH_BIT = 0;
	localparam int FEAT_SELFTEST_LSB = 3;
	localparam int FEAT_SINGLE_BIT  = 5;
	localparam int FEAT_TERM_BIT    = 7;
	localparam int BURST_LEN_LSB    = 0;
	localparam int WR_PRE_BIT       = 2;
	localparam int RD_PRE_BIT       = 3;
	localparam int WR_REC_LSB       = 4;
	localparam int RD_POST_BIT      = 7;
	localparam int LAT_RL_LSB       = 0;
	localparam int LAT_WL_LSB       = 3;
	localparam int LAT_WLSET_BIT    = 6;
	localparam int INV_RD_BIT       = 6;
	localparam int SP_WR_BIT        = 6;
	localparam int SP_OP_BIT        = 7;

	// ----------------------------------------------------------------
	// Values after reset and fixed feature answers
	// ----------------------------------------------------------------
	localparam logic [OP_W-1:0] BURST_RESET = 8'h04;
	localparam logic [2:0]      LAT_RESET   = 3'h0;
	localparam logic            FEAT_REFRESH_MODIFIED_ONLY = 1'h0;
	localparam logic            FEAT_SINGLE_SUPPORT        = 1'h0;
	localparam logic            FEAT_CA_TERMINATED         = 1'h0;

	typedef enum logic [1:0] {
		BL_16    = 2'b00,
		BL_32    = 2'b01,
		BL_OTF   = 2'b10,
		BL_RSVD  = 2'b11
	} lmr_bl_t;

	typedef enum logic [1:0] {
		ST_NONE    = 2'b00,
		ST_LOW     = 2'b01,
		ST_HIGH    = 2'b10,
		ST_GOOD    = 2'b11
	} lmr_selftest_t;

	typedef enum logic [2:0] {
		CMD_NOP       = 3'b000,
		CMD_MRW       = 3'b001,
		CMD_MRR       = 3'b010,
		CMD_READ      = 3'b011,
		CMD_WRITE     = 3'b100,
		CMD_CAL_START = 3'b101,
		CMD_CAL_LATCH = 3'b110
	} lmr_cmd_t;

	// ----------------------------------------------------------------
	// Band tables, index 0 is the slowest band
	// ----------------------------------------------------------------
	localparam logic [LAT_W-1:0] RL_PLAIN [8] = '{6'h06, 6'h0A, 6'h0E, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h24};
	localparam logic [LAT_W-1:0] RL_INV   [8] = '{6'h06, 6'h0C, 6'h10, 6'h16, 6'h1C, 6'h20, 6'h24, 6'h28};
	localparam logic [LAT_W-1:0] WL_SET_A [8] = '{6'h04, 6'h06, 6'h08, 6'h0A, 6'h0C, 6'h0E, 6'h10, 6'h12};
	localparam logic [LAT_W-1:0] WL_SET_B [8] = '{6'h04, 6'h08, 6'h0C, 6'h12, 6'h16, 6'h1A, 6'h1E, 6'h22};
	localparam logic [LAT_W-1:0] WR_REC   [8] = '{6'h06, 6'h0A, 6'h10, 6'h14, 6'h18, 6'h1E, 6'h22, 6'h28};
	localparam logic [LAT_W-1:0] RD_TO_PRE[8] = '{6'h08, 6'h08, 6'h08, 6'h08, 6'h0A, 6'h0C, 6'h0E, 6'h10};
	localparam logic [LAT_W-1:0] RTP_BL32_ADD = 6'h08;
	localparam int BAND_UPPER_MHZ [8] = '{266, 533, 800, 1066, 1333, 1600, 1866, 2133};
	localparam int BAND_LOWEST_MHZ = 10;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS      = 4;
	localparam int CAL_LATCH_WAIT_NS  = 30;
	localparam int CAL_LATCH_WAIT_CYC = (CAL_LATCH_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MEM_CK_MHZ         = 1600;
	localparam int WR_RECOVERY_NS     = 18;

endpackage

// ==== hdl/lmr_link_if.sv ====
`timescale 1ns/100ps
interface lmr_link_if;
	import lmr_pkg::*;

	lmr_cmd_t          cmd_kind;
	logic [MA_W-1:0]   cmd_addr;
	logic [OP_W-1:0]   cmd_data;
	logic              cmd_bl32;
	logic              cmd_ap;
	logic              resp_valid;
	logic [OP_W-1:0]   resp_data;

	modport device (
		input  cmd_kind,
		input  cmd_addr,
		input  cmd_data,
		input  cmd_bl32,
		input  cmd_ap,
		output resp_valid,
		output resp_data
	);

	modport ctrl (
		output cmd_kind,
		output cmd_addr,
		output cmd_data,
		output cmd_bl32,
		output cmd_ap,
		input  resp_valid,
		input  resp_data
	);
endinterface

// ==== hdl/lmr_device.sv ====
`timescale 1ns/100ps
module lmr_device (
	input  wire logic                      i_sys_clk,
	input  wire logic                      i_rst_b,
	lmr_link_if.device                     link,
	input  wire logic [1:0]                i_imp_pin_sense,
	output logic [lmr_pkg::LAT_W-1:0]      o_read_latency,
	output logic [lmr_pkg::LAT_W-1:0]      o_write_latency,
	output logic                           o_burst_32,
	output logic                           o_rd_preamble_toggle,
	output logic                           o_rd_postamble_long,
	output logic                           o_wr_preamble_2ck,
	output logic                           o_factory_trim,
	output logic                           o_cal_run,
	output logic                           o_precharge_start
);
	import lmr_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0]       sense_meta;
		logic [1:0]       sense_sync;
		logic [OP_W-1:0]  burst_sp0;
		logic [OP_W-1:0]  burst_sp1;
		logic             setpoint_write_select;
		logic             setpoint_operate_select;
		logic [2:0]       rl_code;
		logic [2:0]       wl_code;
		logic             wl_set_b;
		logic             rd_invert;
		logic             cal_started;
		logic             cal_waiting;
		logic [3:0]       cal_wait;
		logic [1:0]       impedance_selftest_result;
		logic             factory_trim;
		logic             pre_pend;
		logic [LAT_W-1:0] pre_cnt;
		logic             resp_valid;
		logic [OP_W-1:0]  resp_data;
		logic [LAT_W-1:0] read_latency;
		logic [LAT_W-1:0] write_latency;
		logic             burst_32;
		logic             rd_pre_toggle;
		logic             rd_post_long;
		logic             wr_pre_2ck;
		logic             cal_run;
		logic             precharge_start;
	} lmr_dev_state_t;

	localparam logic [3:0] CAL_WAIT_LOAD = 4'(CAL_LATCH_WAIT_CYC);

	lmr_dev_state_t st;
	lmr_dev_state_t next_st;

	logic [OP_W-1:0] active_burst;
	logic [OP_W-1:0] feature_byte;
	logic [1:0]      active_bl;
	logic [2:0]      active_wr_rec;
	logic            access_bl32;
	logic            cmd_is_cal;
	logic            assembly_fault;

	// ----------------------------------------------------------------
	// Decode of the active set point
	// ----------------------------------------------------------------
	always_comb
	begin
		active_burst  = st.setpoint_operate_select ? st.burst_sp1 : st.burst_sp0;
		active_bl     = active_burst[BURST_LEN_LSB +: 2];
		active_wr_rec = active_burst[WR_REC_LSB +: 3];
		unique case (active_bl)
			BL_32:   access_bl32 = 1'b1;
			BL_OTF:  access_bl32 = link.cmd_bl32;
			default: access_bl32 = 1'b0;
		endcase
		feature_byte = '0;
		feature_byte[FEAT_REFRESH_BIT]             = FEAT_REFRESH_MODIFIED_ONLY;
		feature_byte[FEAT_SELFTEST_LSB +: 2]       = st.impedance_selftest_result;
		feature_byte[FEAT_SINGLE_BIT]              = FEAT_SINGLE_SUPPORT;
		feature_byte[FEAT_TERM_BIT]                = FEAT_CA_TERMINATED;
		cmd_is_cal = (link.cmd_kind == CMD_CAL_START) || (link.cmd_kind == CMD_CAL_LATCH);
		// Only the two fault codes latch the fall-back; good or unsupported keep calibration alive
		assembly_fault = (st.sense_sync == ST_LOW) || (st.sense_sync == ST_HIGH);
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		next_st.sense_meta = i_imp_pin_sense;
		next_st.sense_sync = st.sense_meta;
		next_st.resp_valid = 1'b0;
		next_st.cal_run = 1'b0;
		next_st.precharge_start = 1'b0;

		unique case (link.cmd_kind)
			CMD_MRW:
			begin
				unique case (link.cmd_addr)
					MA_BURST:
					begin
						if (st.setpoint_write_select)
							next_st.burst_sp1 = link.cmd_data;
						else
							next_st.burst_sp0 = link.cmd_data;
					end
					MA_LATENCY:
					begin
						next_st.rl_code  = link.cmd_data[LAT_RL_LSB +: 3];
						next_st.wl_code  = link.cmd_data[LAT_WL_LSB +: 3];
						next_st.wl_set_b = link.cmd_data[LAT_WLSET_BIT];
					end
					MA_INVERT:
						next_st.rd_invert = link.cmd_data[INV_RD_BIT];
					MA_SETPOINT:
					begin
						next_st.setpoint_write_select   = link.cmd_data[SP_WR_BIT];
						next_st.setpoint_operate_select = link.cmd_data[SP_OP_BIT];
					end
					// Writes to the feature register and to unmodelled registers change nothing
					default:
						next_st.resp_valid = 1'b0;
				endcase
			end
			CMD_MRR:
			begin
				next_st.resp_valid = 1'b1;
				unique case (link.cmd_addr)
					MA_FEATURE:
						next_st.resp_data = feature_byte;
					MA_BURST:
						next_st.resp_data = st.setpoint_write_select ? st.burst_sp1 : st.burst_sp0;
					MA_LATENCY:
						next_st.resp_data = {1'b0, st.wl_set_b, st.wl_code, st.rl_code};
					MA_INVERT:
						next_st.resp_data = {1'b0, st.rd_invert, 6'h00};
					MA_SETPOINT:
						next_st.resp_data = {st.setpoint_operate_select, st.setpoint_write_select, 6'h00};
					default:
						next_st.resp_data = 8'h00;
				endcase
			end
			CMD_READ:
			begin
				next_st.burst_32 = access_bl32;
				if (link.cmd_ap)
				begin
					next_st.pre_pend = 1'b1;
					next_st.pre_cnt  = RD_TO_PRE[st.rl_code] + (access_bl32 ? RTP_BL32_ADD : 6'h00);
				end
			end
			CMD_WRITE:
			begin
				next_st.burst_32 = access_bl32;
				if (link.cmd_ap)
				begin
					next_st.pre_pend = 1'b1;
					next_st.pre_cnt  = WR_REC[active_wr_rec];
				end
			end
			CMD_CAL_START:
			begin
				if (!st.factory_trim)
				begin
					next_st.cal_started = 1'b1;
					next_st.cal_run     = 1'b1;
				end
			end
			CMD_CAL_LATCH:
			begin
				if (!st.factory_trim && st.cal_started)
				begin
					next_st.cal_started = 1'b0;
					next_st.cal_waiting = 1'b1;
					next_st.cal_wait    = CAL_WAIT_LOAD;
					next_st.cal_run     = 1'b1;
				end
			end
			default:
				next_st.cal_run = 1'b0;
		endcase

		// A new auto-precharge command restarts the count; the older one is dropped
		if (st.pre_pend && !((link.cmd_kind == CMD_READ || link.cmd_kind == CMD_WRITE) && link.cmd_ap))
		begin
			if (st.pre_cnt <= 6'h01)
			begin
				next_st.pre_pend        = 1'b0;
				next_st.precharge_start = 1'b1;
			end
			else
				next_st.pre_cnt = st.pre_cnt - 6'h01;
		end

		if (st.cal_waiting && !cmd_is_cal)
		begin
			if (st.cal_wait <= 4'h1)
			begin
				next_st.cal_waiting = 1'b0;
				next_st.impedance_selftest_result = st.sense_sync;
				next_st.factory_trim = assembly_fault;
			end
			else
				next_st.cal_wait = st.cal_wait - 4'h1;
		end

		next_st.read_latency  = st.rd_invert ? RL_INV[st.rl_code] : RL_PLAIN[st.rl_code];
		next_st.write_latency = st.wl_set_b ? WL_SET_B[st.wl_code] : WL_SET_A[st.wl_code];
		next_st.rd_pre_toggle = active_burst[RD_PRE_BIT];
		next_st.rd_post_long  = active_burst[RD_POST_BIT];
		// Reserved zero is passed on as-is so a bad setup is visible downstream
		next_st.wr_pre_2ck    = active_burst[WR_PRE_BIT];
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			st <= '0;
			st.burst_sp0 <= BURST_RESET;
			st.burst_sp1 <= BURST_RESET;
			st.rl_code <= LAT_RESET;
			st.wl_code <= LAT_RESET;
			st.read_latency <= RL_PLAIN[0];
			st.write_latency <= WL_SET_A[0];
			st.wr_pre_2ck <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign link.resp_valid       = st.resp_valid;
	assign link.resp_data        = st.resp_data;
	assign o_read_latency        = st.read_latency;
	assign o_write_latency       = st.write_latency;
	assign o_burst_32            = st.burst_32;
	assign o_rd_preamble_toggle  = st.rd_pre_toggle;
	assign o_rd_postamble_long   = st.rd_post_long;
	assign o_wr_preamble_2ck     = st.wr_pre_2ck;
	assign o_factory_trim        = st.factory_trim;
	assign o_cal_run             = st.cal_run;
	assign o_precharge_start     = st.precharge_start;

endmodule

// ==== hdl/lmr_ctrl.sv ====
`timescale 1ns/100ps
module lmr_ctrl (
	input  wire logic                      i_sys_clk,
	input  wire logic                      i_rst_b,
	lmr_link_if.ctrl                       link,
	input  wire logic                      i_req_valid,
	input  wire lmr_pkg::lmr_cmd_t         i_req_kind,
	input  wire logic [lmr_pkg::MA_W-1:0]  i_req_addr,
	input  wire logic [lmr_pkg::OP_W-1:0]  i_req_data,
	input  wire logic                      i_req_bl32,
	input  wire logic                      i_req_ap,
	input  wire logic [1:0]                i_burst_mode,
	output logic                           o_req_ready,
	output logic                           o_resp_valid,
	output logic [lmr_pkg::OP_W-1:0]       o_resp_data,
	output logic [lmr_pkg::LAT_W-1:0]      o_read_latency,
	output logic [lmr_pkg::LAT_W-1:0]      o_write_latency
);
	import lmr_pkg::*;

	// ----------------------------------------------------------------
	// Settings fixed by the clock rate
	// ----------------------------------------------------------------
	function automatic logic [2:0] band_of(input int mhz);
		logic [2:0] b;
		b = 3'h7;
		for (int i = 7; i >= 0; i--)
			if (mhz <= BAND_UPPER_MHZ[i])
				b = 3'(i);
		return b;
	endfunction

	function automatic logic [2:0] wr_code_of(input int need);
		logic [2:0] c;
		c = 3'h7;
		for (int i = 7; i >= 0; i--)
			if (int'(WR_REC[i]) >= need)
				c = 3'(i);
		return c;
	endfunction

	// Band is picked from the clock rate, so no setting leaves its band
	localparam logic [2:0] CK_BAND   = band_of(MEM_CK_MHZ);
	localparam int         WR_NEED   = (WR_RECOVERY_NS * MEM_CK_MHZ + 999) / 1000;
	localparam logic [2:0] WR_CODE   = wr_code_of(WR_NEED);

	typedef struct packed {
		lmr_cmd_t         kind;
		logic [MA_W-1:0]  addr;
		logic [OP_W-1:0]  data;
		logic             bl32;
		logic             ap;
		logic             wl_set_b;
		logic             rd_invert;
		logic             ready;
		logic             resp_valid;
		logic [OP_W-1:0]  resp_data;
		logic [LAT_W-1:0] read_latency;
		logic [LAT_W-1:0] write_latency;
	} lmr_ctrl_state_t;

	lmr_ctrl_state_t st;
	lmr_ctrl_state_t next_st;
	logic [1:0]      bl_code;

	always_comb
	begin
		// Reserved mode falls back to fixed 16 beats
		bl_code = (i_burst_mode == BL_RSVD) ? BL_16 : i_burst_mode;
		next_st = st;
		next_st.ready      = 1'b1;
		next_st.kind       = CMD_NOP;
		next_st.ap         = 1'b0;
		next_st.bl32       = 1'b0;
		next_st.resp_valid = link.resp_valid;
		next_st.resp_data  = link.resp_valid ? link.resp_data : st.resp_data;
		if (i_req_valid)
		begin
			next_st.kind = i_req_kind;
			next_st.addr = i_req_addr;
			next_st.data = i_req_data;
			next_st.ap   = i_req_ap;
			next_st.bl32 = (bl_code == BL_32) || ((bl_code == BL_OTF) && i_req_bl32);
			if (i_req_kind == CMD_MRW)
			begin
				unique case (i_req_addr)
					MA_BURST:
					begin
						// Burst code follows i_burst_mode at each write, so both set points agree only while it holds
						next_st.data[BURST_LEN_LSB +: 2] = bl_code;
						next_st.data[WR_PRE_BIT]         = 1'b1;
						next_st.data[WR_REC_LSB +: 3]    = WR_CODE;
					end
					MA_LATENCY:
					begin
						next_st.data[LAT_RL_LSB +: 3] = CK_BAND;
						next_st.data[LAT_WL_LSB +: 3] = CK_BAND;
						next_st.wl_set_b = i_req_data[LAT_WLSET_BIT];
					end
					MA_INVERT:
						next_st.rd_invert = i_req_data[INV_RD_BIT];
					default:
						next_st.ready = 1'b1;
				endcase
			end
		end
		next_st.read_latency  = st.rd_invert ? RL_INV[CK_BAND] : RL_PLAIN[CK_BAND];
		next_st.write_latency = st.wl_set_b ? WL_SET_B[CK_BAND] : WL_SET_A[CK_BAND];
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			st <= '0;
			st.read_latency <= RL_PLAIN[0];
			st.write_latency <= WL_SET_A[0];
		end
		else
			st <= next_st;
	end

	assign link.cmd_kind    = st.kind;
	assign link.cmd_addr    = st.addr;
	assign link.cmd_data    = st.data;
	assign link.cmd_bl32    = st.bl32;
	assign link.cmd_ap      = st.ap;
	assign o_req_ready      = st.ready;
	assign o_resp_valid     = st.resp_valid;
	assign o_resp_data      = st.resp_data;
	assign o_read_latency   = st.read_latency;
	assign o_write_latency  = st.write_latency;

endmodule

// ==== dv/lmr_asserts.sv ====
`timescale 1ns/100ps
module lmr_asserts (
	input wire logic                      i_sys_clk,
	input wire logic                      i_rst_b,
	input wire lmr_pkg::lmr_cmd_t         cmd_kind,
	input wire logic [lmr_pkg::MA_W-1:0]  cmd_addr,
	input wire logic [lmr_pkg::OP_W-1:0]  cmd_data,
	input wire logic                      cmd_bl32,
	input wire logic                      cmd_ap,
	input wire logic                      resp_valid,
	input wire logic [lmr_pkg::OP_W-1:0]  resp_data
);
	import lmr_pkg::*;

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_b);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	logic latch_seen;
	wire  mrw_burst = (cmd_kind == CMD_MRW) && (cmd_addr == MA_BURST);
	wire  mrr_feat  = (cmd_kind == CMD_MRR) && (cmd_addr == MA_FEATURE);

	// Self-test may only leave 00 once a latch has been sent since reset
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			latch_seen <= 1'b0;
		else if (cmd_kind == CMD_CAL_LATCH)
			latch_seen <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_mrr_answer_time: assert property (cmd_kind == CMD_MRR |=> resp_valid)
		else $error("read not answered in the next cycle");
	chk_no_stray_resp: assert property (resp_valid |-> $past(cmd_kind) == CMD_MRR)
		else $error("answer without a read");
	chk_refresh_bit: assert property (mrr_feat |=> resp_data[FEAT_REFRESH_BIT] == FEAT_REFRESH_MODIFIED_ONLY)
		else $error("refresh support bit wrong");
	chk_selftest_clear: assert property (mrr_feat && !latch_seen |=> resp_data[4:3] == 2'h0)
		else $error("self-test result shown before calibration");
	chk_single_bit: assert property (mrr_feat |=> resp_data[FEAT_SINGLE_BIT] == FEAT_SINGLE_SUPPORT)
		else $error("single-ended bit wrong");
	chk_term_bit: assert property (mrr_feat |=> resp_data[FEAT_TERM_BIT] == FEAT_CA_TERMINATED)
		else $error("termination bit wrong");
	chk_burst_code_legal: assert property (mrw_burst |-> cmd_data[1:0] != BL_RSVD)
		else $error("reserved burst code written");
	chk_wr_preamble_set: assert property (mrw_burst |-> cmd_data[WR_PRE_BIT])
		else $error("write preamble bit written as zero");
	chk_wr_rec_code: assert property (mrw_burst |-> cmd_data[6:4] == 3'h5)
		else $error("write recovery code not rounded up");

	cov_feat_read: cover property (mrr_feat);
	cov_burst_write: cover property (mrw_burst);
	cov_cal_latch: cover property (cmd_kind == CMD_CAL_LATCH);
	cov_read_ap_32: cover property (cmd_kind == CMD_READ && cmd_ap && cmd_bl32);
endmodule

// ==== dv/lmr_test.sv ====
`timescale 1ns/100ps
module lmr_test;
	import lmr_pkg::*;

	logic             i_sys_clk, i_rst_b, rv, rb, rp;
	lmr_cmd_t         rk;
	logic [MA_W-1:0]  ra;
	logic [OP_W-1:0]  rd, c_rd;
	logic [1:0]       bm, pin;
	logic [LAT_W-1:0] d_rl, d_wl, c_rl, c_wl;
	logic             d_b32, d_pre_t, d_post_l, d_wpre, d_trim, d_cal, d_pc, c_ready, c_rv;
	int               n_fail = 0;
	int               checked = 0;
	int               cycles = 0;
	int               cal_hits = 0;

	lmr_link_if i_lmr_link_if ();
	lmr_device i_lmr_device (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .link(i_lmr_link_if),
		.i_imp_pin_sense(pin), .o_read_latency(d_rl), .o_write_latency(d_wl), .o_burst_32(d_b32),
		.o_rd_preamble_toggle(d_pre_t), .o_rd_postamble_long(d_post_l), .o_wr_preamble_2ck(d_wpre),
		.o_factory_trim(d_trim), .o_cal_run(d_cal), .o_precharge_start(d_pc));
	lmr_ctrl i_lmr_ctrl (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .link(i_lmr_link_if), .i_req_valid(rv),
		.i_req_kind(rk), .i_req_addr(ra), .i_req_data(rd), .i_req_bl32(rb), .i_req_ap(rp), .i_burst_mode(bm),
		.o_req_ready(c_ready), .o_resp_valid(c_rv), .o_resp_data(c_rd), .o_read_latency(c_rl),
		.o_write_latency(c_wl));
	lmr_asserts i_lmr_asserts (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .cmd_kind(i_lmr_link_if.cmd_kind),
		.cmd_addr(i_lmr_link_if.cmd_addr), .cmd_data(i_lmr_link_if.cmd_data), .cmd_bl32(i_lmr_link_if.cmd_bl32),
		.cmd_ap(i_lmr_link_if.cmd_ap), .resp_valid(i_lmr_link_if.resp_valid),
		.resp_data(i_lmr_link_if.resp_data));

	// ----------------------------------------------------------------
	// Clock, hang guard, calibration pulse count
	// ----------------------------------------------------------------
	initial
	begin
		i_sys_clk = 1'b0;
		forever #2 i_sys_clk = ~i_sys_clk;
	end

	// The whole run needs well under a thousand cycles
	always @(posedge i_sys_clk)
	begin
		cycles++;
		if (d_cal === 1'b1)
			cal_hits++;
		if (cycles == 4000)
		begin
			n_fail++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic end_sim;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic do_reset;
		@(posedge i_sys_clk);
		i_rst_b <= 1'b0;
		repeat (2) @(posedge i_sys_clk);
		i_rst_b <= 1'b1;
		@(posedge i_sys_clk);
		#1;
	endtask

	// Returns at the edge that takes the request
	task automatic req(input lmr_cmd_t k, input logic [MA_W-1:0] a, input logic [OP_W-1:0] d, input logic b,
		input logic p);
		@(posedge i_sys_clk);
		rv <= 1'b1;
		rk <= k;
		ra <= a;
		rd <= d;
		rb <= b;
		rp <= p;
		@(posedge i_sys_clk);
		rv <= 1'b0;
	endtask

	task automatic mode_reg_read_cmd(input logic [MA_W-1:0] a, output logic [OP_W-1:0] q);
		req(CMD_MRR, a, 8'h00, 1'b0, 1'b0);
		// Answer stands in the cycle after the second edge past the taking edge
		repeat (2) @(posedge i_sys_clk);
		#1;
		cmp(16'(c_rv), 16'h0001);
		q = c_rd;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		cmp(16'({d_rl, d_wl}), 16'({6'h06, 6'h04}));
		cmp(16'({c_ready, d_wpre, d_b32, d_trim}), 16'h000C);
		$display("reset test done");
	endtask

	task automatic t_feature;
		logic [7:0] q;
		mode_reg_read_cmd(MA_FEATURE, q);
		cmp(16'(q[0]), 16'(FEAT_REFRESH_MODIFIED_ONLY));
		cmp(16'(q[4:3]), 16'h0000);
		cmp(16'(q[5]), 16'(FEAT_SINGLE_SUPPORT));
		cmp(16'(q[7]), 16'(FEAT_CA_TERMINATED));
		$display("feature test done");
	endtask

	// Ends in per-command mode, which the precharge test relies on
	task automatic t_burst;
		logic [1:0] ms [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
		logic [7:0] q;
		logic [7:0] d;
		for (int i = 0; i < 4; i++)
		begin
			d = {ms[i][0], 3'h0, ms[i][0], 3'h0};
			@(posedge i_sys_clk);
			bm <= ms[i];
			req(CMD_MRW, MA_BURST, d, 1'b0, 1'b0);
			mode_reg_read_cmd(MA_BURST, q);
			cmp(16'(q), 16'({d[7], 3'h5, d[3], 1'b1, (ms[i] == 2'h3) ? 2'h0 : ms[i]}));
			cmp(16'({d_post_l, d_pre_t}), 16'({d[7], d[3]}));
		end
		$display("burst test done");
	endtask

	task automatic t_setpoint;
		logic [7:0] q;
		req(CMD_MRW, MA_SETPOINT, 8'h40, 1'b0, 1'b0);
		req(CMD_MRW, MA_BURST, 8'h88, 1'b0, 1'b0);
		mode_reg_read_cmd(MA_BURST, q);
		cmp(16'(q), 16'h00DE);
		cmp(16'({d_post_l, d_pre_t}), 16'h0000);
		req(CMD_MRW, MA_SETPOINT, 8'h80, 1'b0, 1'b0);
		mode_reg_read_cmd(MA_BURST, q);
		cmp(16'(q), 16'h0056);
		cmp(16'({d_post_l, d_pre_t}), 16'h0003);
		$display("setpoint test done");
	endtask

	task automatic t_latency;
		logic [11:0] e;
		for (int i = 0; i < 2; i++)
		begin
			e = i ? {6'h20, 6'h0E} : {6'h1C, 6'h1A};
			req(CMD_MRW, MA_INVERT, {1'b0, i[0], 6'h00}, 1'b0, 1'b0);
			req(CMD_MRW, MA_LATENCY, {1'b0, ~i[0], 6'h00}, 1'b0, 1'b0);
			repeat (4) @(posedge i_sys_clk);
			#1;
			cmp(16'({d_rl, d_wl}), 16'(e));
			cmp(16'({c_rl, c_wl}), 16'(e));
		end
		$display("latency test done");
	endtask

	task automatic t_precharge;
		lmr_cmd_t pk [3] = '{CMD_READ, CMD_READ, CMD_WRITE};
		logic     pb [3] = '{1'b0, 1'b1, 1'b0};
		int       pn [3] = '{12, 20, 30};
		int       n;
		for (int i = 0; i < 3; i++)
		begin
			req(pk[i], 6'h00, 8'h00, pb[i], 1'b1);
			n = 0;
			do
			begin
				@(posedge i_sys_clk);
				#1;
				n++;
			end
			while (d_pc !== 1'b1 && n < 60);
			cmp(16'(n), 16'(pn[i] + 1));
			cmp(16'(d_b32), 16'(pb[i]));
		end
		$display("precharge test done");
	endtask

	// A fault code freezes the result until reset, so the last pass resets first
	task automatic t_cal;
		logic [1:0] pv [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
		logic [1:0] ev [4] = '{2'h3, 2'h2, 2'h2, 2'h1};
		int         hv [4] = '{2, 4, 4, 6};
		logic [7:0] q;
		for (int i = 0; i < 4; i++)
		begin
			if (i == 3)
			begin
				do_reset();
				t_reset();
				t_feature();
			end
			@(posedge i_sys_clk);
			pin <= pv[i];
			req(CMD_CAL_START, 6'h00, 8'h00, 1'b0, 1'b0);
			req(CMD_CAL_LATCH, 6'h00, 8'h00, 1'b0, 1'b0);
			repeat (14) @(posedge i_sys_clk);
			mode_reg_read_cmd(MA_FEATURE, q);
			cmp(16'(q[4:3]), 16'(ev[i]));
			cmp(16'(d_trim), 16'(i > 0));
			cmp(16'(cal_hits), 16'(hv[i]));
		end
		$display("calibration test done");
	endtask

	initial
	begin
		{rv, rb, rp, ra, rd, bm, pin} = '0;
		rk = CMD_NOP;
		i_rst_b = 1'b0;
		do_reset();
		t_reset();
		t_feature();
		t_burst();
		t_setpoint();
		t_latency();
		t_precharge();
		t_cal();
		end_sim();
	end
endmodule
